// file: common/adc_mux_map.svh
// Purpose: widths, field positions, reset values and timing counts
// Assumes: ref_clk at 40 MHz
// Notes: constants only, no logic
`ifndef ADC_MUX_MAP_SVH
`define ADC_MUX_MAP_SVH

// ----------------------------------------
// result word layout
// ----------------------------------------
`define RES_WIDTH 10
`define COARSE_WIDTH 4
`define FINE_WIDTH 6
`define RES_TOP_BIT 9
`define RES_BOTTOM_BIT 0
`define RES_RESET 10'h000

// ----------------------------------------
// channel codes
// ----------------------------------------
`define CHAN_RESET 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define REF_CLK_HZ 40000000
`define MAX_SAMPLE_HZ 250000
// least converter period in ref_clk cycles, rounded up
`define MIN_CONV_CYCLES ((`REF_CLK_HZ + `MAX_SAMPLE_HZ - 1) / `MAX_SAMPLE_HZ)

`endif

// file: common/adc_mux_pkg.sv
// Purpose: types shared by the converter control files
// Assumes: nothing
// Notes: constants live in adc_mux_map.svh
package adc_mux_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    conv_idle,
    conv_coarse,
    conv_fine,
    conv_merge
  } conv_state_t;

  typedef enum logic {
    mode_single,
    mode_continuous
  } conv_mode_t;

endpackage

// file: src/result_buffer.sv
// Purpose: two-entry buffer on the result path
// Assumes: one clock, synchronous active-low reset
// Notes: ready to the source is full-honest, no word lost on stall
`timescale 1ns/100ps
module result_buffer
  import adc_mux_pkg::*;
#(
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0] count;
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;
  logic push;
  logic pop;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign in_ready = (state_reg.count != 2'h2);
  assign out_valid = (state_reg.count != 2'h0);
  assign out_data = state_reg.slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // slot0 is always the head so the output is straight from a flop
  always_comb begin
    state_next = state_reg;
    if (pop) begin
      state_next.slot0 = state_reg.slot1;
    end
    if (push) begin
      if (state_reg.count == 2'h0 ||
          (state_reg.count == 2'h1 && pop)) begin
        state_next.slot0 = in_data;
      end else if (pop) begin
        state_next.slot1 = in_data;
      end else begin
        state_next.slot1 = in_data;
      end
    end
    state_next.count = state_reg.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  a_buf_no_overfill: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg.count <= 2'h2)
    else $error("buffer count above two");

endmodule

// file: src/adc_mux_control.sv
// Purpose: digital side of a two-step 10-bit converter with 4-input mux
// Assumes: conv_clk pin and host strobes are asynchronous to ref_clk;
//   comparator outputs come from the analog core on ref_clk
// Notes: one result per converter clock rising edge, except edges mid-conversion in single mode and words merged while asleep or into a full buffer
`timescale 1ns/100ps
`include "adc_mux_map.svh"
module adc_mux_control
  import adc_mux_pkg::*;
#(
  parameter int MIN_CONV = `MIN_CONV_CYCLES
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // host channel select pins (pull-downs modelled outside)
  input wire logic write_strobe_n,
  input wire logic channel_sel_hi,
  input wire logic channel_sel_lo,
  // converter clock pin and mode
  input wire logic conv_clk,
  input wire logic continuous_mode,
  input wire logic sleep_request,
  // analog core interface
  output logic [1:0] analog_select,
  output logic coarse_strobe,
  output logic fine_strobe,
  input wire logic [3:0] coarse_code,
  input wire logic [5:0] fine_code,
  input wire logic over_range_in,
  // result outputs
  output logic [9:0] result_word,
  output logic over_range_flag,
  output logic rate_fault,
  output logic result_valid,
  input wire logic result_ready
);

  typedef struct packed {
    logic [2:0] sync_wr1;
    logic [2:0] sync_wr2;
    logic [1:0] sync_ck;
    logic [1:0] sync_sl;
    logic conv_clk_prev;
    logic [1:0] chan;
    conv_state_t phase;
    logic [3:0] coarse;
    logic [5:0] fine;
    logic ovr;
    logic [9:0] word;
    logic flag;
    logic push;
    logic [15:0] period;
    logic fault;
    logic pending;
  } ctl_state_t;

  ctl_state_t s_reg;
  ctl_state_t s_next;
  logic buf_ready;
  logic buf_valid;
  logic [10:0] buf_data;
  logic wr_low;
  logic ck_rise;
  logic sleeping;

  // ----------------------------------------
  // synchronised pins
  // ----------------------------------------
  assign wr_low = !s_reg.sync_wr2[2];
  assign ck_rise = s_reg.sync_ck[1] && !s_reg.conv_clk_prev;
  assign sleeping = s_reg.sync_sl[1];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.push = 1'b0;
    s_next.sync_wr1 = {write_strobe_n, channel_sel_hi, channel_sel_lo};
    s_next.sync_wr2 = s_reg.sync_wr1;
    s_next.sync_ck = {s_reg.sync_ck[0], conv_clk};
    s_next.sync_sl = {s_reg.sync_sl[0], sleep_request};
    s_next.conv_clk_prev = s_reg.sync_ck[1];
    // transparent latch while strobe low, hold while high
    if (wr_low) begin
      s_next.chan = s_reg.sync_wr2[1:0];
    end
    // period watch: flag converter clocks faster than rated
    if (ck_rise) begin
      s_next.fault = (s_reg.period < 16'(MIN_CONV - 1));
      s_next.period = 16'h0000;
    end else if (s_reg.period != 16'hffff) begin
      s_next.period = s_reg.period + 16'h0001;
    end
    // a second edge during a conversion is remembered in continuous mode
    if (ck_rise && s_reg.phase != conv_idle && continuous_mode) begin
      s_next.pending = 1'b1;
    end
    case (s_reg.phase)
      conv_idle: begin
        if (ck_rise || s_reg.pending) begin
          s_next.pending = 1'b0;
          s_next.phase = conv_coarse;
        end
      end
      conv_coarse: begin
        s_next.coarse = coarse_code;
        s_next.ovr = over_range_in;
        s_next.phase = conv_fine;
      end
      conv_fine: begin
        s_next.fine = fine_code;
        s_next.phase = conv_merge;
      end
      conv_merge: begin
        // frozen outputs while asleep, word dropped
        if (!sleeping) begin
          s_next.word = {s_reg.coarse, s_reg.fine};
          s_next.flag = s_reg.ovr;
          s_next.push = 1'b1;
        end
        s_next.phase = conv_idle;
      end
      default: begin
        s_next.phase = conv_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.chan <= `CHAN_RESET;
      s_reg.word <= `RES_RESET;
      s_reg.phase <= conv_idle;
      s_reg.sync_wr1 <= 3'h0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign analog_select = s_reg.chan;
  assign coarse_strobe = (s_reg.phase == conv_coarse);
  assign fine_strobe = (s_reg.phase == conv_fine);
  assign rate_fault = s_reg.fault;
  // buffer head feeds the pins; buffer full drops a word, not stalls
  // asleep, nothing enters or leaves, so the pins cannot move
  assign result_word = buf_data[9:0];
  assign over_range_flag = buf_data[10];
  assign result_valid = buf_valid;

  result_buffer #(
    .WIDTH(11)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(s_reg.push && !sleeping),
    .in_ready(buf_ready),
    .in_data({s_reg.flag, s_reg.word}),
    .out_valid(buf_valid),
    .out_ready(result_ready && !sleeping),
    .out_data(buf_data)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_chan_follows: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && wr_low |=> analog_select == $past(s_reg.sync_wr2[1:0]))
    else $error("channel not latched while strobe low");
  a_chan_holds: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !wr_low |=> $stable(analog_select))
    else $error("channel moved while strobe high");
  a_sleep_freeze: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sleeping && $past(sleeping) |-> $stable(result_word))
    else $error("result changed while asleep");
  a_sleep_valid: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sleeping && $past(sleeping) |-> $stable(result_valid))
    else $error("result valid moved while asleep");
  a_two_step: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && coarse_strobe |=> fine_strobe)
    else $error("fine step did not follow coarse");
  a_merge_word: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_reg.push |-> s_reg.word[9:6] == $past(s_reg.coarse))
    else $error("coarse bits not on top");
  a_flag_with_word: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_reg.push |-> s_reg.flag == $past(s_reg.ovr))
    else $error("flag not updated with word");
  a_start_conv: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && ck_rise && s_reg.phase == conv_idle |=> coarse_strobe)
    else $error("edge did not start conversion");
  a_fault_fast: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && ck_rise && s_reg.period < 16'(MIN_CONV - 1) |=> rate_fault)
    else $error("fast clock not flagged");

  c_single: cover property (@(posedge ref_clk) s_reg.push && !continuous_mode);
  c_pipe: cover property (@(posedge ref_clk) s_reg.pending);
  c_sleep: cover property (@(posedge ref_clk) sleeping && buf_valid);
  c_full: cover property (@(posedge ref_clk) !buf_ready);

endmodule

// file: bench/host_model.sv
// Purpose: host model, channel select, conversion pacing, reads
// Assumes: pins change at the falling edge of ref_clk
// Notes: pins start at the pull-down level; the strobe stays high after a pick
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic ref_clk,
  // channel pins
  output logic write_strobe_n,
  output logic channel_sel_hi,
  output logic channel_sel_lo,
  // converter clock and read side
  output logic conv_clk,
  output logic result_ready
);
  // open pins pulled low: latch open on channel 0
  initial begin
    write_strobe_n = 1'b0;
    {channel_sel_hi, channel_sel_lo} = 2'h0;
    conv_clk = 1'b0;
    result_ready = 1'b0;
  end
  // strobe low long enough to pass the synchroniser
  task automatic pick(input logic [1:0] ch);
    @(negedge ref_clk);
    {channel_sel_hi, channel_sel_lo} = ch;
    write_strobe_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    write_strobe_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
  // address moves while the strobe stays high: must be ignored
  task automatic stray(input logic [1:0] ch);
    {channel_sel_hi, channel_sel_lo} = ch;
    repeat (6) @(negedge ref_clk);
  endtask
  // caller sets the period, at least gap plus three cycles; pulse(0) is under the rate floor
  task automatic pulse(input int gap);
    @(negedge ref_clk);
    conv_clk = 1'b1;
    repeat (2) @(negedge ref_clk);
    conv_clk = 1'b0;
    repeat (gap) @(negedge ref_clk);
  endtask
  // one-cycle pop request, a clock after the last drive
  task automatic take();
    @(negedge ref_clk);
    result_ready = 1'b1;
    @(negedge ref_clk);
    result_ready = 1'b0;
  endtask
endmodule

// file: bench/adc_mux_control_tb.sv
// Purpose: self-checking bench for adc_mux_control
// Assumes: 40 MHz ref_clk, short rate floor of 4 cycles
// Notes: analog core codes driven straight by the bench
`timescale 1ns/100ps
module adc_mux_control_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic write_strobe_n, channel_sel_hi, channel_sel_lo, conv_clk;
  logic clk_en, continuous_mode, sleep_request, over_range_in;
  logic [3:0] coarse_code;
  logic [5:0] fine_code;
  logic [1:0] analog_select;
  logic [9:0] result_word;
  logic over_range_flag, result_valid, result_ready;
  logic coarse_strobe, fine_strobe, rate_fault;
  int miscompares = 0;
  int comparisons = 0;
  int n_coarse = 0;
  int n_fine = 0;

  always #12.5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // device and host
  // ----------------------------------------
  adc_mux_control #(.MIN_CONV(4)) adc_mux_control_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .write_strobe_n(write_strobe_n), .channel_sel_hi(channel_sel_hi),
    .channel_sel_lo(channel_sel_lo), .conv_clk(conv_clk),
    .continuous_mode(continuous_mode), .sleep_request(sleep_request),
    .analog_select(analog_select), .coarse_strobe(coarse_strobe),
    .fine_strobe(fine_strobe),
    .coarse_code(coarse_code), .fine_code(fine_code),
    .over_range_in(over_range_in), .result_word(result_word),
    .over_range_flag(over_range_flag), .rate_fault(rate_fault),
    .result_valid(result_valid), .result_ready(result_ready));
  host_model host_model_inst (
    .ref_clk(ref_clk), .write_strobe_n(write_strobe_n),
    .channel_sel_hi(channel_sel_hi), .channel_sel_lo(channel_sel_lo),
    .conv_clk(conv_clk), .result_ready(result_ready));

  // one strobe of each kind per started conversion, sampled mid-cycle
  always @(negedge ref_clk) begin
    if (coarse_strobe === 1'b1) begin
      n_coarse++;
    end
    if (fine_strobe === 1'b1) begin
      n_fine++;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait: a lost word shows as a mismatch, not a hang
  task automatic wait_word(input logic [10:0] exp);
    int n;
    n = 0;
    while (result_valid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check({over_range_flag, result_word}, exp);
  endtask
  task automatic load(input logic [10:0] w);
    {over_range_in, coarse_code, fine_code} = w;
  endtask
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_select();
    check(analog_select, 2'h0);
    for (int c = 3; c >= 0; c--) begin
      host_model_inst.pick(c[1:0]);
      check(analog_select, c[1:0]);
    end
    host_model_inst.stray(2'h3);
    check(analog_select, 2'h0);
  endtask
  task automatic t_convert();
    load(11'h6ad);
    host_model_inst.pulse(8);
    wait_word(11'h6ad);
    // enable low: the pop request must leave the buffer alone
    clk_en = 1'b0;
    host_model_inst.take();
    check({result_valid, over_range_flag, result_word}, 12'head);
    clk_en = 1'b1;
    host_model_inst.take();
    check(result_valid, 1'b0);
    load(11'h255);
    host_model_inst.pulse(8);
    wait_word(11'h255);
    host_model_inst.take();
    check(rate_fault, 1'b0);
  endtask
  // asleep: head frozen, pop refused, new word discarded
  task automatic t_sleep();
    load(11'h3c1);
    host_model_inst.pulse(8);
    wait_word(11'h3c1);
    sleep_request = 1'b1;
    load(11'h03e);
    // let the pin pass the synchroniser before asking for a pop
    repeat (2) @(negedge ref_clk);
    host_model_inst.take();
    host_model_inst.pulse(12);
    check({result_valid, over_range_flag, result_word}, 12'hbc1);
    sleep_request = 1'b0;
    repeat (3) @(negedge ref_clk);
    host_model_inst.take();
    repeat (12) @(negedge ref_clk);
    check(result_valid, 1'b0);
  endtask
  // an edge three cycles after the first lands mid-conversion
  task automatic t_stream();
    // single mode: that edge is dropped, and the rate is flagged
    load(11'h123);
    host_model_inst.pulse(0);
    host_model_inst.pulse(24);
    wait_word(11'h123);
    host_model_inst.take();
    check(result_valid, 1'b0);
    check(rate_fault, 1'b1);
    // continuous mode: it is remembered; host stalls, order kept
    continuous_mode = 1'b1;
    load(11'h123);
    host_model_inst.pulse(0);
    fork
      host_model_inst.pulse(24);
      begin
        // after the first fine step, before the second coarse step
        repeat (3) @(negedge ref_clk);
        load(11'h4d2);
      end
    join
    wait_word(11'h123);
    host_model_inst.take();
    wait_word(11'h4d2);
    host_model_inst.take();
    check(result_valid, 1'b0);
    // seven conversions started over the whole run
    check(12'(n_coarse), 12'h007);
    check(12'(n_fine), 12'h007);
  endtask

  // watchdog sized well past the planned run
  initial begin
    #75000;
    miscompares++;
    close_out();
  end
  initial begin
    clk_en = 1'b1;
    continuous_mode = 1'b0;
    sleep_request = 1'b0;
    load(11'h000);
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    t_select();
    t_convert();
    t_sleep();
    t_stream();
    close_out();
  end
endmodule
